// *** cal_seq_pkg.sv ***
// Constants, reset values and carrier types shared by the calibration sequencer files.
// Assumes an 8-bit register port behind the serial control port and one 25 MHz core clock.
package cal_seq_pkg;

    // Register offsets on the 12-bit register address.
    localparam logic [11:0] AVG_CAL_CONTROL_ADDR  = 12'h00E2;
    localparam logic [11:0] CAL_CLOCK_SETUP_ADDR  = 12'h00E7;
    localparam logic [11:0] CAL_CONV_PAGE_ADDR    = 12'h00E8;
    localparam logic [11:0] CAL_CTRL_STATUS_ADDR  = 12'h00E9;
    localparam logic [11:0] CAL_INIT_ADDR         = 12'h00ED;

    // Field positions.
    localparam int AVG_ARM_BIT     = 0;
    localparam int AVG_TRIGGER_BIT = 1;
    localparam int CLK_GATE_BIT    = 3;
    localparam int CAL_APPLY_BIT   = 0;
    localparam int CAL_TRIGGER_BIT = 1;
    localparam int OVR_LOW_BIT     = 4;
    localparam int OVR_HIGH_BIT    = 5;
    localparam int RUNNING_BIT     = 6;
    localparam int DONE_BIT        = 7;

    // Reset values and the good init preset.
    localparam logic [3:0] CLK_SETUP_UPPER_RST = 4'h3;
    localparam logic [3:0] CAL_PAGE_RST        = 4'hF;
    localparam logic [7:0] CAL_INIT_RST        = 8'hA6;
    localparam logic [7:0] CAL_INIT_GOOD       = 8'hA2;

    // Timing: length of one calibration run in calibration clock ticks.
    localparam int CLK_PERIOD_NS  = 40;
    localparam int CAL_RUN_NS     = 1600;
    localparam int CAL_RUN_CYCLES = (CAL_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Number of converter cores.
    localparam int NUM_DACS = 4;

    // Per-converter state seen by the register read path.
    typedef struct packed {
        logic       done;       // Run has completed.
        logic       running;    // Run in progress.
        logic       ovr_high;   // Overrange high seen in last run.
        logic       ovr_low;    // Overrange low seen in last run.
        logic       trigger;    // Stored per-converter trigger bit.
        logic       apply;      // Stored apply bit.
        logic [7:0] init;       // Calibration initialisation value.
    } cal_stat_t;

endpackage : cal_seq_pkg

// *** cal_core_unit.sv ***
// One converter's calibration engine: control bits, init value, run timer and result flags.
// Assumes write strobes already steered by the converter page mask in the parent.
`timescale 1ns/1ps
module cal_core_unit
    import cal_seq_pkg::*;
#(
    parameter int RUN_CYCLES = CAL_RUN_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic       wr_ctrl,     // Write to control/status, this converter paged.
    input  wire logic       wr_init,     // Write to init register, this converter paged.
    input  wire logic [7:0] wdata,
    input  wire logic       avg_start,   // One-cycle averaged start pulse.
    input  wire logic       clk_en,      // Calibration clock gate.
    output cal_stat_t       stat
);

    localparam int CW = $clog2(RUN_CYCLES + 1);

    logic          trig_q;              // Stored trigger bit.
    logic          apply_q;             // Stored apply bit.
    logic [7:0]    init_q;              // Init value.
    logic          run_q;
    logic          done_q;
    logic          hi_q;
    logic          lo_q;
    logic [CW-1:0] cnt_q;               // Ticks of the current run.

    // A rising edge of the stored trigger bit, or the averaged pulse, starts a run.
    wire trig_rise = wr_ctrl & wdata[CAL_TRIGGER_BIT] & ~trig_q;
    wire start     = (trig_rise | avg_start) & ~run_q;
    // The run only advances while the calibration clock is enabled.
    wire tick      = run_q & clk_en;
    wire last      = tick & (cnt_q == CW'(RUN_CYCLES - 1));
    // A wrong init preset pushes the calibration DACs out of range.
    wire ovr_hi    = init_q > CAL_INIT_GOOD;
    wire ovr_lo    = init_q < CAL_INIT_GOOD;

    // Control bits and init value written by software.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            trig_q  <= 1'b0;
            apply_q <= 1'b0;
            init_q  <= CAL_INIT_RST;
        end else begin
            if (wr_ctrl) begin
                trig_q  <= wdata[CAL_TRIGGER_BIT];
                apply_q <= wdata[CAL_APPLY_BIT];
            end
            if (wr_init) begin
                init_q <= wdata;
            end
        end
    end

    // Run timer and result flags; done and running swap in one cycle.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            run_q  <= 1'b0;
            done_q <= 1'b0;
            hi_q   <= 1'b0;
            lo_q   <= 1'b0;
            cnt_q  <= '0;
        end else if (start) begin
            run_q  <= 1'b1;
            done_q <= 1'b0;
            hi_q   <= 1'b0;
            lo_q   <= 1'b0;
            cnt_q  <= '0;
        end else if (last) begin
            run_q  <= 1'b0;
            done_q <= 1'b1;
            hi_q   <= ovr_hi;
            lo_q   <= ovr_lo;
        end else if (tick) begin
            cnt_q  <= cnt_q + CW'(1);
        end
    end

    assign stat = '{done: done_q, running: run_q, ovr_high: hi_q, ovr_low: lo_q,
                    trigger: trig_q, apply: apply_q, init: init_q};

    AST_START_RUNS: assert property (@(posedge core_clk) disable iff (!rstn)
        start |=> run_q && !done_q)
        else $error("Start did not begin a run.");

    AST_END_SWAP: assert property (@(posedge core_clk) disable iff (!rstn)
        ($fell(run_q) && $past(rstn)) |-> done_q && (hi_q == $past(ovr_hi))
            && (lo_q == $past(ovr_lo)))
        else $error("Run ended without finished flag and valid overrange flags.");

    AST_NOT_BOTH: assert property (@(posedge core_clk) disable iff (!rstn)
        run_q |-> !done_q)
        else $error("Running and finished flags high together.");

    AST_VALID_CLASS: assert property (@(posedge core_clk) disable iff (!rstn)
        // The preset judged is the one that stood while the run ended, not a later write.
        $rose(done_q) |-> ((hi_q || lo_q) == ($past(init_q) != CAL_INIT_GOOD)))
        else $error("Overrange classification does not match init preset.");

    AST_GATE_STALL: assert property (@(posedge core_clk) disable iff (!rstn)
        (run_q && !clk_en && !start) |=> run_q && $stable(cnt_q))
        else $error("Run advanced with calibration clock gated.");

endmodule : cal_core_unit

// *** dac_self_calibration_control.sv ***
// Notes on behaviour
// - Averaged trigger rising edge calibrates all converters.
// - Averaged arm must be set; results apply while set.
// - Clock gate bit enables calibration clock, resets off.
// - Four-bit page mask selects converters, resets all.
// - Page mask steers control/status and init accesses.
// - Finished flag high after completed run, reset low.
// - Finished with overrange flag means invalid, timeout.
// - Running flag high throughout a run only.
// - Per-converter trigger edge starts paged converters.
// - Apply bit high needed for coefficients to apply; code also applies them while averaged arm set.
//
// Top of the calibration sequencer: register port, page steering and four engines.
// Assumes the serial control port delivers one-cycle read and write strobes on core_clk.
`timescale 1ns/1ps
module dac_self_calibration_control
    import cal_seq_pkg::*;
#(
    parameter int RUN_CYCLES = CAL_RUN_CYCLES
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic [11:0]         reg_addr,     // Register address.
    input  wire logic [7:0]          reg_wdata,    // Write data.
    input  wire logic                reg_wr,       // One-cycle write strobe.
    input  wire logic                reg_rd,       // One-cycle read strobe.
    output logic      [7:0]          reg_rdata,    // Read data, valid with reg_rvalid.
    output logic                     reg_rvalid,   // One-cycle read answer.
    output logic                     cal_clk_en,   // Calibration clock gate.
    output logic      [NUM_DACS-1:0] cal_apply,    // Coefficients applied per converter.
    output logic      [NUM_DACS-1:0] cal_busy      // Calibration running per converter.
);

    // Software-visible registers.
    logic [3:0]          clk_upper_q;              // Stored upper nibble of clock setup.
    logic                clk_gate_q;               // Calibration clock enable bit.
    logic [3:0]          page_q;                   // Converter page mask.
    logic                avg_arm_q;                // Averaged arm bit.
    logic                avg_trig_q;               // Averaged trigger bit.
    cal_stat_t           stat [NUM_DACS];          // Per-converter state.
    logic [NUM_DACS-1:0] unit_done;
    logic [NUM_DACS-1:0] unit_run;
    logic [NUM_DACS-1:0] unit_ok;

    // Address decode as named wires.
    wire wr_avg   = reg_wr & (reg_addr == AVG_CAL_CONTROL_ADDR);
    wire wr_clk   = reg_wr & (reg_addr == CAL_CLOCK_SETUP_ADDR);
    wire wr_page  = reg_wr & (reg_addr == CAL_CONV_PAGE_ADDR);
    wire wr_ctrl  = reg_wr & (reg_addr == CAL_CTRL_STATUS_ADDR);
    wire wr_init  = reg_wr & (reg_addr == CAL_INIT_ADDR);

    // Averaged start needs a rising trigger edge while armed.
    wire avg_rise  = wr_avg & reg_wdata[AVG_TRIGGER_BIT] & ~avg_trig_q;
    wire avg_start = avg_rise & (reg_wdata[AVG_ARM_BIT] | avg_arm_q);

    // Readback picks the lowest paged converter; with more than one page bit set the
    // answer is only that converter's, which is why software should page one at a time.
    logic [1:0] rd_sel;
    always_comb begin
        rd_sel = 2'd0;
        for (int i = NUM_DACS - 1; i >= 0; i--) begin
            if (page_q[i]) begin
                rd_sel = 2'(i);
            end
        end
    end

    wire cal_stat_t sel_stat = stat[rd_sel];
    wire [7:0] ctrl_rd = {sel_stat.done, sel_stat.running, sel_stat.ovr_high,
                          sel_stat.ovr_low, 2'b00, sel_stat.trigger, sel_stat.apply};

    // Read multiplexer; unmapped and reserved bits read zero.
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            AVG_CAL_CONTROL_ADDR: rd_mux = {6'h00, avg_trig_q, avg_arm_q};
            CAL_CLOCK_SETUP_ADDR: rd_mux = {clk_upper_q, clk_gate_q, 3'b000};
            CAL_CONV_PAGE_ADDR:   rd_mux = {4'h0, page_q};
            CAL_CTRL_STATUS_ADDR: rd_mux = ctrl_rd;
            CAL_INIT_ADDR:        rd_mux = sel_stat.init;
            default:              rd_mux = 8'h00;
        endcase
    end

    // Global control registers.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            clk_upper_q <= CLK_SETUP_UPPER_RST;
            clk_gate_q  <= 1'b0;
            page_q      <= CAL_PAGE_RST;
            avg_arm_q   <= 1'b0;
            avg_trig_q  <= 1'b0;
        end else begin
            if (wr_clk) begin
                // Upper nibble is stored as written; keeping it at default is software's job.
                clk_upper_q <= reg_wdata[7:4];
                clk_gate_q  <= reg_wdata[CLK_GATE_BIT];
            end
            if (wr_page) begin
                page_q <= reg_wdata[3:0];
            end
            if (wr_avg) begin
                avg_arm_q  <= reg_wdata[AVG_ARM_BIT];
                avg_trig_q <= reg_wdata[AVG_TRIGGER_BIT];
            end
        end
    end

    // One engine per converter; writes reach only the paged ones.
    genvar g;
    generate
        for (g = 0; g < NUM_DACS; g++) begin : g_dac
            cal_core_unit #(
                .RUN_CYCLES (RUN_CYCLES)
            ) u_unit (
                .core_clk  (core_clk),
                .rstn      (rstn),
                .wr_ctrl   (wr_ctrl & page_q[g]),
                .wr_init   (wr_init & page_q[g]),
                .wdata     (reg_wdata),
                .avg_start (avg_start),
                .clk_en    (clk_gate_q),
                .stat      (stat[g])
            );
            assign unit_done[g] = stat[g].done;
            assign unit_run[g]  = stat[g].running;
            // Only a valid finished run may apply coefficients.
            assign unit_ok[g]   = stat[g].done & ~stat[g].ovr_high & ~stat[g].ovr_low
                                  & (stat[g].apply | avg_arm_q);
        end
    endgenerate

    // Registered outputs and read answer.
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
            cal_clk_en <= 1'b0;
            cal_apply  <= '0;
            cal_busy   <= '0;
        end else begin
            reg_rdata  <= reg_rd ? rd_mux : reg_rdata;
            reg_rvalid <= reg_rd;
            cal_clk_en <= clk_gate_q;
            cal_apply  <= unit_ok;
            cal_busy   <= unit_run;
        end
    end

    AST_CLK_GATE_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rstn)
        wr_clk |=> ##1 (cal_clk_en == $past(reg_wdata[CLK_GATE_BIT], 2)))
        else $error("Calibration clock gate does not follow written bit.");

    AST_AVG_ALL_START: assert property (@(posedge core_clk) disable iff (!rstn)
        (avg_start && unit_run == '0) |=> (unit_run == '1) && (unit_done == '0))
        else $error("Averaged trigger did not start every converter.");

    AST_AVG_NEEDS_ARM: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_avg && !reg_wdata[AVG_ARM_BIT] && !avg_arm_q && !wr_ctrl && unit_run == '0)
        |=> unit_run == '0)
        else $error("Averaged calibration started without arm bit.");

    AST_PAGE_STEER: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_ctrl && !avg_start && unit_run == '0) |=> ((unit_run & ~$past(page_q)) == '0))
        else $error("Unpaged converter started calibration.");

    AST_READ_ANSWER: assert property (@(posedge core_clk) disable iff (!rstn)
        (reg_rd && reg_addr == CAL_CTRL_STATUS_ADDR)
        |=> reg_rvalid && (reg_rdata[DONE_BIT] == $past(sel_stat.done))
            && (reg_rdata[RUNNING_BIT] == $past(sel_stat.running)))
        else $error("Status readback wrong or late.");

endmodule : dac_self_calibration_control

// *** host_port_model.sv ***
// Host software model: issues register writes and reads one at a time.
// Assumes the bench clock; it changes the request lines only on falling edges.
`timescale 1ns/1ps
module host_port_model
    import cal_seq_pkg::*;
(
    input  wire logic        core_clk,
    output logic      [11:0] reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    // Idle request lines from time zero.
    initial begin
        reg_addr  = 12'h0000;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One write held across exactly one rising edge.
    // Released lines show the inverse so stale values never look valid.
    task automatic write_reg(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        // The clock setup upper nibble is always written at its default.
        if (a == CAL_CLOCK_SETUP_ADDR) v[7:4] = CLK_SETUP_UPPER_RST;
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        @(negedge core_clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~v;
    endtask : write_reg

    // One read strobe; the answer is judged by the bench monitor.
    task automatic read_reg(input logic [11:0] a);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge core_clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
    endtask : read_reg
endmodule : host_port_model

// *** tb.sv ***
// Self-checking bench for the calibration sequencer, driven through the host model.
// Assumes the sequencer package and host model are compiled first.
`timescale 1ns/1ps
module tb;
    import cal_seq_pkg::*;

    logic                core_clk;
    logic                rstn;
    logic [11:0]         reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_rdata;
    logic                reg_rvalid;
    logic                cal_clk_en;
    logic [NUM_DACS-1:0] cal_apply;
    logic [NUM_DACS-1:0] cal_busy;
    logic [7:0]          exp_q[$];   // Expected read data, oldest first.
    int                  n_errors;
    int                  num_checks;
    logic [7:0]          v;          // Init value under test.

    // A four-tick run keeps every calibration short.
    dac_self_calibration_control #(.RUN_CYCLES(4)) uut (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .cal_clk_en(cal_clk_en), .cal_apply(cal_apply), .cal_busy(cal_busy));

    host_port_model host (.core_clk(core_clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    // Free-running 25 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // One comparison; a mismatch is reported at once.
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        num_checks++;
        if (got !== ex) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        host.write_reg(a, d);
    endtask : wr

    // The note goes on the queue before the strobe so the monitor finds it.
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.read_reg(a);
    endtask : rd

    // Busy must show the started set, then clear within a bounded wait.
    task automatic run_cal(input logic [3:0] eb);
        int i;
        repeat (3) @(negedge core_clk);
        chk("busy", {4'h0, eb}, {4'h0, cal_busy});
        for (i = 0; i < 200 && cal_busy !== 4'h0; i++) @(negedge core_clk);
        chk("busy_end", 8'h00, {4'h0, cal_busy});
    endtask : run_cal

    // Monitor: each read answer takes the oldest note off the queue.
    always @(negedge core_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("[ERR] rdata expected none seen %h", reg_rdata);
            end else begin
                chk("rdata", exp_q.pop_front(), reg_rdata);
            end
        end
    end

    // Single exit; unanswered reads count against the run.
    task automatic wrap_up();
        n_errors += exp_q.size();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // Watchdog: the tests need about 170 cycles.
    initial begin
        #200000;
        n_errors++;
        $display("[ERR] watchdog expected end seen timeout");
        wrap_up();
    end

    initial begin
        rstn = 1'b0;
        n_errors = 0;
        num_checks = 0;
        v = 8'($urandom(78889));
        // Rising edges are counted so the clock's start-up value cannot shorten reset.
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        // Reset values, and an unmapped location reading zero.
        chk("clk_en", 8'h00, {7'h0, cal_clk_en});
        chk("apply", 8'h00, {4'h0, cal_apply});
        rd(AVG_CAL_CONTROL_ADDR, 8'h00);
        rd(CAL_CLOCK_SETUP_ADDR, 8'h30);
        rd(CAL_CONV_PAGE_ADDR, 8'h0F);
        rd(CAL_CTRL_STATUS_ADDR, 8'h00);
        rd(CAL_INIT_ADDR, 8'hA6);
        wr(12'h00E3, 8'hFF);
        rd(12'h00E3, 8'h00);
        wr(CAL_CLOCK_SETUP_ADDR, 8'h38);
        repeat (2) @(negedge core_clk);
        chk("clk_en", 8'h01, {7'h0, cal_clk_en});
        $display("test reset_and_gate done");
        // Two converters paged together; the others stay untouched.
        wr(CAL_CONV_PAGE_ADDR, 8'h06);
        wr(CAL_INIT_ADDR, 8'hA2);
        wr(CAL_CTRL_STATUS_ADDR, 8'h03);
        run_cal(4'h6);
        chk("apply", 8'h06, {4'h0, cal_apply});
        wr(CAL_CONV_PAGE_ADDR, 8'h02);
        rd(CAL_CTRL_STATUS_ADDR, 8'h83);
        wr(CAL_CONV_PAGE_ADDR, 8'h01);
        rd(CAL_CTRL_STATUS_ADDR, 8'h00);
        rd(CAL_INIT_ADDR, 8'hA6);
        $display("test per_dac done");
        // Gate off stalls a run; the default init ends overrange high.
        wr(CAL_CLOCK_SETUP_ADDR, 8'h30);
        repeat (2) @(negedge core_clk);
        chk("clk_en", 8'h00, {7'h0, cal_clk_en});
        wr(CAL_CONV_PAGE_ADDR, 8'h08);
        wr(CAL_CTRL_STATUS_ADDR, 8'h03);
        rd(CAL_CTRL_STATUS_ADDR, 8'h43);
        repeat (8) @(negedge core_clk);
        chk("busy_stall", 8'h08, {4'h0, cal_busy});
        wr(CAL_CLOCK_SETUP_ADDR, 8'h38);
        run_cal(4'h8);
        rd(CAL_CTRL_STATUS_ADDR, 8'hA3);
        chk("apply", 8'h06, {4'h0, cal_apply});
        $display("test stall done");
        // Averaged run over all four; arm alone lets converter 0 apply.
        wr(CAL_INIT_ADDR, 8'hA2);
        wr(CAL_CONV_PAGE_ADDR, 8'h01);
        wr(CAL_INIT_ADDR, 8'hA2);
        wr(AVG_CAL_CONTROL_ADDR, 8'h01);
        wr(AVG_CAL_CONTROL_ADDR, 8'h03);
        run_cal(4'hF);
        chk("apply", 8'h0F, {4'h0, cal_apply});
        wr(AVG_CAL_CONTROL_ADDR, 8'h00);
        repeat (2) @(negedge core_clk);
        chk("apply", 8'h0E, {4'h0, cal_apply});
        wr(AVG_CAL_CONTROL_ADDR, 8'h02);
        repeat (3) @(negedge core_clk);
        chk("busy_unarmed", 8'h00, {4'h0, cal_busy});
        rd(AVG_CAL_CONTROL_ADDR, 8'h02);
        rd(CAL_CTRL_STATUS_ADDR, 8'h80);
        $display("test averaged done");
        // The good preset, then three random init values, judge the overrange outcome.
        for (int k = 0; k < 4; k++) begin
            if (k > 0) v = 8'($urandom_range(255, 0));
            else v = CAL_INIT_GOOD;
            wr(CAL_CTRL_STATUS_ADDR, 8'h01);
            wr(CAL_INIT_ADDR, v);
            wr(CAL_CTRL_STATUS_ADDR, 8'h03);
            run_cal(4'h1);
            rd(CAL_CTRL_STATUS_ADDR, v > 8'hA2 ? 8'hA3 : (v < 8'hA2 ? 8'h93 : 8'h83));
            chk("apply", {4'h0, 3'b111, v == 8'hA2}, {4'h0, cal_apply});
        end
        $display("test random_init done");
        // Arm and trigger in one write start all four; a reset mid-run restores defaults.
        wr(AVG_CAL_CONTROL_ADDR, 8'h00);
        wr(AVG_CAL_CONTROL_ADDR, 8'h03);
        repeat (2) @(negedge core_clk);
        chk("busy_armed", 8'h0F, {4'h0, cal_busy});
        rstn = 1'b0;
        repeat (3) @(negedge core_clk);
        rstn = 1'b1;
        chk("busy_rst", 8'h00, {4'h0, cal_busy});
        chk("apply_rst", 8'h00, {4'h0, cal_apply});
        chk("clk_en_rst", 8'h00, {7'h0, cal_clk_en});
        rd(CAL_CTRL_STATUS_ADDR, 8'h00);
        rd(CAL_CONV_PAGE_ADDR, 8'h0F);
        rd(AVG_CAL_CONTROL_ADDR, 8'h00);
        $display("test mid_reset done");
        repeat (3) @(negedge core_clk);
        wrap_up();
    end
endmodule : tb
